// ===== verilog/sdi_tx_driver.sv
// Host-side driver for the SDI transmit control pins, with Wishbone registers.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module sdi_tx_driver
   import sdi_tx_pkg::*;
#(
   parameter int W = 20,
   parameter int DEPTH = 16,
   parameter int RST_CYCLES = 8,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic reset,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Video word source
   input wire logic srcValid,
   input wire logic [W-1:0] srcData,
   output logic srcReady,
   // Transmitter control pins
   output logic txRst,
   output logic [2:0] txCe,
   output logic txDinRdy,
   output logic [1:0] txMode,
   output logic levelBSelect,
   output logic txFracSel,
   output logic [W-1:0] txWord
);
   localparam int HW = $clog2(RST_CYCLES + 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(RST_CYCLES - 1);

   ctrl_type ctrl_reg;
   seq_type seq_reg;
   logic [HW-1:0] holdCnt_reg;
   logic invalid_reg;
   logic [15:0] under_reg;
   logic dinPhase_reg;
   logic [31:0] statusWord;
   logic busHit, wrCtrl, wrStatus, rstNow, cePulse, rdyNext, take;
   logic lvlBMode, reseq;
   logic fifoValid, fifoFull;
   logic [W-1:0] fifoData;
   logic [CW-1:0] fifoLevel;

   ////////////////////////////////////////////////////////////////////////
   // Register bus

   assign busHit = cyc_i && stb_i;
   // Writes land at the edge where ack is seen high
   assign wrCtrl = busHit && we_i && ack_o && (adr_i == ADDR_CTRL) && sel_i[0];
   assign wrStatus = busHit && we_i && ack_o && (adr_i == ADDR_STATUS);
   assign reseq = wrCtrl && (dat_i[CTRL_MODE_LSB +: 2] != MODE_BAD)
      && ((dat_i[CTRL_MODE_LSB +: 2] != ctrl_reg.mode) || (dat_i[CTRL_LVLB_BIT] != ctrl_reg.levelB));

   always_comb begin
      statusWord = ZERO_WORD;
      statusWord[ST_HOLD_BIT] = (seq_reg == SEQ_HOLD);
      statusWord[ST_EMPTY_BIT] = !fifoValid;
      statusWord[ST_FULL_BIT] = fifoFull;
      statusWord[ST_INV_BIT] = invalid_reg;
      statusWord[ST_LEVEL_LSB +: CW] = fifoLevel;
      statusWord[ST_UNDER_LSB +: 16] = under_reg;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ack_o <= 1'b0;
         dat_o <= ZERO_WORD;
      end else begin
         ack_o <= busHit && !ack_o;
         if (busHit && !ack_o) begin
            if (adr_i == ADDR_CTRL) begin
               dat_o <= ZERO_WORD | 32'(ctrl_reg);
            end else if (adr_i == ADDR_STATUS) begin
               dat_o <= statusWord;
            end else begin
               dat_o <= ZERO_WORD;
            end
         end
      end
   end

   // Invalid code is refused; the old mode stays in force
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_reg.txReset <= dat_i[CTRL_RST_BIT];
         ctrl_reg.levelB <= dat_i[CTRL_LVLB_BIT];
         ctrl_reg.frac <= dat_i[CTRL_FRAC_BIT];
         if (dat_i[CTRL_MODE_LSB +: 2] != MODE_BAD) begin
            ctrl_reg.mode <= dat_i[CTRL_MODE_LSB +: 2];
         end
      end
   end

   // Sticky error: a new bad write wins over a clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         invalid_reg <= 1'b0;
      end else if (wrCtrl && (dat_i[CTRL_MODE_LSB +: 2] == MODE_BAD)) begin
         invalid_reg <= 1'b1;
      end else if (wrStatus && sel_i[0] && dat_i[ST_INV_BIT]) begin
         invalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencing: hold after reset, on request and on mode change

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         seq_reg <= SEQ_HOLD;
         holdCnt_reg <= '0;
      end else begin
         case (seq_reg)
            SEQ_HOLD: begin
               if (reseq) begin
                  holdCnt_reg <= '0;
               end else if (holdCnt_reg != HOLD_LAST) begin
                  holdCnt_reg <= HW'(holdCnt_reg + 1'b1);
               end else if (!ctrl_reg.txReset) begin
                  seq_reg <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (reseq || (wrCtrl && dat_i[CTRL_RST_BIT])) begin
                  seq_reg <= SEQ_HOLD;
                  holdCnt_reg <= '0;
               end
            end
            default: begin
               seq_reg <= SEQ_HOLD;
               holdCnt_reg <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin generation; all pins are flops on mclk

   assign rstNow = (seq_reg == SEQ_HOLD);
   assign lvlBMode = (ctrl_reg.mode == MODE_3G) && ctrl_reg.levelB;
   // Alternate cycles only in 3G level B
   assign rdyNext = rstNow || !lvlBMode || !dinPhase_reg;
   // A word moves only on an enabled, valid cycle
   assign take = !rstNow && cePulse && rdyNext;

   sdi_ce_cadence u_cadence (
      .mclk(mclk),
      .reset(reset),
      .restart(rstNow),
      .sdMode(ctrl_reg.mode == MODE_SD),
      .pulse(cePulse)
   );

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txRst <= 1'b1;
         txMode <= MODE_HD;
         levelBSelect <= 1'b0;
      end else begin
         txRst <= rstNow;
         txMode <= ctrl_reg.mode;
         levelBSelect <= ctrl_reg.levelB;
      end
   end

   // Steers the serializer PLL mux; low = 1/1.000, high = 1/1.001
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txFracSel <= 1'b0;
      end else begin
         txFracSel <= ctrl_reg.frac;
      end
   end

   // One flop per copy to spread the load forced high in reset
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txCe <= 3'h7;
      end else begin
         for (int i = 0; i < 3; i++) begin
            txCe[i] <= rstNow || cePulse;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txDinRdy <= 1'b1;
         dinPhase_reg <= 1'b0;
      end else begin
         txDinRdy <= rdyNext;
         dinPhase_reg <= rstNow ? 1'b0 : !dinPhase_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data path

   sdi_word_fifo #(
      .W(W),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .inValid(srcValid),
      .inData(srcData),
      .inReady(srcReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(take),
      .level(fifoLevel)
   );

   assign fifoFull = !srcReady;

   // Starved slots send zero words; counter saturates, a clear in the same cycle as an increment loads one
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txWord <= '0;
         under_reg <= '0;
      end else begin
         if (take) begin
            txWord <= fifoValid ? fifoData : '0;
         end
         if (take && !fifoValid) begin
            if (wrStatus && (sel_i[3:2] != 2'h0)) begin
               under_reg <= UNDER_ONE;
            end else if (under_reg != UNDER_MAX) begin
               under_reg <= 16'(under_reg + 1'b1);
            end
         end else if (wrStatus && (sel_i[3:2] != 2'h0)) begin
            under_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   logic sdRun, lvlBRun;
   assign sdRun = (txMode == MODE_SD) && !txRst;
   assign lvlBRun = (txMode == MODE_3G) && levelBSelect && !txRst;

   property p_ce_copies;
      (txCe == 3'h0) || (txCe == 3'h7);
   endproperty
   a_ce_copies: assert property (p_ce_copies) else $error("enable copies differ");

   property p_rst_high;
      txRst |-> (txCe == 3'h7) && txDinRdy;
   endproperty
   a_rst_high: assert property (p_rst_high) else $error("enable or valid low during reset");

   property p_fast_ce;
      (txMode != MODE_SD) ##1 (txMode != MODE_SD) |-> txCe[0];
   endproperty
   a_fast_ce: assert property (p_fast_ce) else $error("enable dropped in HD or 3G");

   property p_sd_gap;
      sdRun && txCe[0] ##1 sdRun |-> (!txCe[0] || !sdRun) [*4];
   endproperty
   a_sd_gap: assert property (p_sd_gap) else $error("SD enable spaced too close");

   property p_sd_next;
      sdRun && txCe[0] |-> ##[5:6] txCe[0];
   endproperty
   a_sd_next: assert property (p_sd_next) else $error("SD enable spaced too far");

   property p_sd_alt;
      sdRun && txCe[0] && $past(txCe[0], 5) && !$past(txCe[0], 1) && $past(sdRun, 6) |-> ##6 (txCe[0] || !sdRun);
   endproperty
   a_sd_alt: assert property (p_sd_alt) else $error("SD cadence not alternating");

   property p_lvlb_alt;
      lvlBRun && txDinRdy ##1 lvlBRun |-> !txDinRdy ##1 (txDinRdy || !lvlBRun);
   endproperty
   a_lvlb_alt: assert property (p_lvlb_alt) else $error("level B valid not alternating");

   property p_lvla_rdy;
      !((txMode == MODE_3G) && levelBSelect) |-> txDinRdy;
   endproperty
   a_lvla_rdy: assert property (p_lvla_rdy) else $error("valid low outside level B");

   property p_no_bad;
      txMode != MODE_BAD;
   endproperty
   a_no_bad: assert property (p_no_bad) else $error("invalid rate code on pins");

   property p_frac;
      wrCtrl |-> ##2 (txFracSel == $past(dat_i[CTRL_FRAC_BIT], 2));
   endproperty
   a_frac: assert property (p_frac) else $error("PLL select not following write");

   property p_ack;
      busHit && !ack_o |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack not one cycle");

   c_sd_run: cover property (sdRun && txCe[0] ##5 txCe[0] ##6 txCe[0]);
   c_lvlb: cover property (lvlBRun && txDinRdy ##1 !txDinRdy ##1 txDinRdy);
   c_bad_write: cover property (wrCtrl && (dat_i[CTRL_MODE_LSB +: 2] == MODE_BAD));
   c_under: cover property (take && !fifoValid);
endmodule // sdi_tx_driver

// ===== verilog/sdi_tx_pkg.sv
// Constants, types and field layout for the SDI transmit driver.
package sdi_tx_pkg;
   // Word clock figures; mclk must be this clock itself
   localparam int HD_CLK_KHZ = 74_250;
   localparam int G3_CLK_KHZ = 148_500;
   localparam int SD_WORD_KHZ = 27_000;

   localparam logic [1:0] MODE_HD = 2'h0;
   localparam logic [1:0] MODE_SD = 2'h1;
   localparam logic [1:0] MODE_3G = 2'h2;
   localparam logic [1:0] MODE_BAD = 2'h3;

   // Enable spacing in SD mode, alternating
   localparam logic [2:0] GAP_SHORT = 3'h5;
   localparam logic [2:0] GAP_LONG = 3'h6;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   localparam int CTRL_RST_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_LVLB_BIT = 3;
   localparam int CTRL_FRAC_BIT = 4;

   localparam int ST_HOLD_BIT = 0;
   localparam int ST_EMPTY_BIT = 1;
   localparam int ST_FULL_BIT = 2;
   localparam int ST_INV_BIT = 3;
   localparam int ST_LEVEL_LSB = 8;
   localparam int ST_UNDER_LSB = 16;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [15:0] UNDER_ONE = 16'h0001;
   localparam logic [15:0] UNDER_MAX = 16'hFFFF;

   typedef struct packed {
      logic frac;
      logic levelB;
      logic [1:0] mode;
      logic txReset;
   } ctrl_type;

   localparam ctrl_type CTRL_RESET = '{frac: 1'b0, levelB: 1'b0, mode: MODE_HD, txReset: 1'b0};

   typedef enum logic [1:0] {
      SEQ_HOLD = 2'b01,
      SEQ_RUN = 2'b10
   } seq_type;
endpackage

// ===== verilog/sdi_word_fifo.sv
// Word FIFO between the video source and the transmit word output.
`timescale 1ns/1ps
module sdi_word_fifo #(
   parameter int W = 20,
   parameter int DEPTH = 16,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady,
   output logic [CW-1:0] level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLC = CW'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg, rdPtr_reg;
   logic [CW-1:0] levelNext;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == LAST) ? '0 : AW'(p + 1'b1);
   endfunction

   assign push = inValid && inReady;
   assign pop = outReady && outValid;
   assign outData = mem[rdPtr_reg];

   always_comb begin
      levelNext = level;
      if (push && !pop) begin
         levelNext = CW'(level + 1'b1);
      end else if (pop && !push) begin
         levelNext = CW'(level - 1'b1);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         level <= '0;
         inReady <= 1'b1;
         outValid <= 1'b0;
      end else begin
         if (push) wrPtr_reg <= bump(wrPtr_reg);
         if (pop) rdPtr_reg <= bump(rdPtr_reg);
         level <= levelNext;
         // Flags are flops so the source sees a clean ready
         inReady <= (levelNext != FULLC);
         outValid <= (levelNext != '0);
      end
   end
endmodule // sdi_word_fifo

// ===== verilog/sdi_ce_cadence.sv
// Word enable cadence: steady high, or 5/6 spaced pulses for SD.
`timescale 1ns/1ps
module sdi_ce_cadence
   import sdi_tx_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic restart,
   input wire logic sdMode,
   output logic pulse
);
   logic [2:0] cnt_reg;
   logic longNext_reg;

   // Average 148.5/5.5 = 27 MHz in SD steady otherwise
   assign pulse = !sdMode || (cnt_reg == '0);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt_reg <= '0;
         longNext_reg <= 1'b0;
      end else if (restart || !sdMode) begin
         cnt_reg <= '0;
         longNext_reg <= 1'b0;
      end else if (cnt_reg == '0) begin
         cnt_reg <= longNext_reg ? 3'(GAP_LONG - 1'b1) : 3'(GAP_SHORT - 1'b1);
         longNext_reg <= !longNext_reg;
      end else begin
         cnt_reg <= 3'(cnt_reg - 1'b1);
      end
   end
endmodule // sdi_ce_cadence

// ===== bench/sdi_tx_model.sv
// Behavioural transmitter that consumes the driver's control pins and word stream.
`timescale 1ns/1ps
module sdi_tx_model
   import sdi_tx_pkg::*;
#(
   parameter int W = 20
) (
   input wire logic mclk,
   input wire logic txRst,
   input wire logic [2:0] txCe,
   input wire logic txDinRdy,
   input wire logic [1:0] txMode,
   input wire logic levelBSelect,
   input wire logic txFracSel,
   input wire logic [W-1:0] txWord,
   output logic [15:0] wordCount,
   output logic [W-1:0] lastWord,
   output logic [7:0] faults,
   output logic pllSel,
   output logic mapB
);
   logic take;
   logic bad;
   ////////////////////////////////////////////////////////////////////////////////
   // Everything is sampled on the one word clock
   initial faults = 8'h00;
   assign pllSel = txFracSel;
   assign mapB = (txMode == MODE_3G) && levelBSelect;
   assign take = !txRst && txCe[0] && txDinRdy && (txWord != '0);
   always_comb begin
      bad = (txCe != 3'h0 && txCe != 3'h7) || (txMode == MODE_BAD);
      if (txRst && (txCe != 3'h7 || !txDinRdy)) begin
         bad = 1'b1;
      end
      // Zero words are underrun fill, so only real words join the sequence
      if (take && wordCount != 16'h0000 && txWord != lastWord + 1'b1) begin
         bad = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      faults <= faults + {7'h00, bad};
      if (txRst) begin
         wordCount <= 16'h0000;
         lastWord <= '0;
      end else if (take) begin
         wordCount <= wordCount + 16'h0001;
         lastWord <= txWord;
      end
   end
endmodule // sdi_tx_model

// ===== bench/sdi_tx_driver_tb.sv
// Self-checking bench for the SDI transmit driver, its FIFO and register bus.
`timescale 1ns/1ps
module sdi_tx_driver_tb
   import sdi_tx_pkg::*;
;
   localparam int DEPTH = 16;
   logic mclk = 1'b0;
   logic reset = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, srcValid = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] datW = 32'h0000_0000;
   logic [19:0] srcData = 20'h0_0000;
   logic [31:0] datR, rdData;
   logic ack, srcReady, txRst, txDinRdy, levelBSelect, txFracSel, pllSel, mapB;
   logic [2:0] txCe;
   logic [1:0] txMode;
   logic [19:0] txWord, lastWord;
   logic [15:0] wordCount;
   logic [7:0] faults;
   int failures = 0;
   int checked = 0;
   int nextWord = 1;

   always #2 mclk = ~mclk;

   sdi_tx_driver #(.W(20), .DEPTH(DEPTH), .RST_CYCLES(8)) sdi_tx_driver_i (.mclk(mclk), .reset(reset),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
      .srcValid(srcValid), .srcData(srcData), .srcReady(srcReady), .txRst(txRst), .txCe(txCe),
      .txDinRdy(txDinRdy), .txMode(txMode), .levelBSelect(levelBSelect), .txFracSel(txFracSel), .txWord(txWord));
   sdi_tx_model #(.W(20)) sdi_tx_model_i (.mclk(mclk), .txRst(txRst), .txCe(txCe), .txDinRdy(txDinRdy),
      .txMode(txMode), .levelBSelect(levelBSelect), .txFracSel(txFracSel), .txWord(txWord),
      .wordCount(wordCount), .lastWord(lastWord), .faults(faults), .pllSel(pllSel), .mapB(mapB));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Waits as long as the slave needs; only the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      sel <= s;
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      rdData = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // Hold the word up until the FIFO takes it; back to back words keep valid high
   task automatic push(input int cnt);
      int n;
      n = 0;
      @(posedge mclk);
      for (int i = 0; i < cnt; i++) begin
         srcValid <= 1'b1;
         srcData <= 20'(nextWord);
         do begin
            @(posedge mclk);
            n++;
         end while (srcReady !== 1'b1 && n < 200);
         nextWord++;
      end
      srcValid <= 1'b0;
   endtask

   // Returns at the edge closing the first cycle with the transmitter out of reset
   task automatic waitRun();
      int n;
      n = 0;
      repeat (2) @(posedge mclk);
      do begin
         @(posedge mclk);
         n++;
      end while (txRst !== 1'b0 && n < 100);
      if (n >= 100) failures++;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic testReset();
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData[ST_HOLD_BIT], 1'b1);
      cmp({txRst, txCe, txDinRdy, txMode, levelBSelect, txFracSel}, 9'h1F0);
      waitRun();
      cmp({txRst, txCe, txDinRdy}, 5'h0F);
      $display("reset test done");
   endtask

   task automatic testHd();
      push(4);
      repeat (20) begin
         @(posedge mclk);
         cmp({txCe, txDinRdy}, 4'hF);
      end
      cmp(wordCount, 4);
      cmp(lastWord, nextWord - 1);
      $display("hd test done");
   endtask

   task automatic testSd();
      int last;
      int k;
      last = 0;
      k = 0;
      wb(1'b1, ADDR_CTRL, 32'h0000_0002, 4'hF);
      waitRun();
      cmp({txMode, txCe}, 5'h0F);
      for (int i = 1; i < 60 && k < 8; i++) begin
         @(posedge mclk);
         if (txCe === 3'h7) begin
            cmp(i - last, (k % 2) ? 6 : 5);
            last = i;
            k++;
         end
      end
      cmp(k, 8);
      push(3);
      repeat (60) @(posedge mclk);
      cmp(wordCount, 3);
      cmp(lastWord, nextWord - 1);
      $display("sd test done");
   endtask

   task automatic test3g();
      wb(1'b1, ADDR_CTRL, 32'h0000_000C, 4'hF);
      waitRun();
      cmp({txMode, mapB}, 3'h5);
      for (int i = 0; i < 8; i++) begin
         cmp(txDinRdy, 32'(i % 2 == 0));
         @(posedge mclk);
      end
      wb(1'b1, ADDR_CTRL, 32'h0000_0004, 4'hF);
      waitRun();
      repeat (8) begin
         cmp({txDinRdy, mapB, txCe}, 5'h17);
         @(posedge mclk);
      end
      $display("3g test done");
   endtask

   task automatic testFrac();
      wb(1'b1, ADDR_CTRL, 32'h0000_0014, 4'hF);
      repeat (2) @(posedge mclk);
      cmp({txFracSel, pllSel, txRst}, 3'h6);
      wb(1'b1, ADDR_CTRL, 32'h0000_0016, 4'hF);
      repeat (2) @(posedge mclk);
      cmp({txMode, txRst}, 3'h4);
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData[ST_INV_BIT], 1'b1);
      wb(1'b1, ADDR_STATUS, 32'h0000_0008, 4'h1);
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData[ST_INV_BIT], 1'b0);
      wb(1'b1, ADDR_CTRL, 32'h0000_0004, 4'hF);
      repeat (2) @(posedge mclk);
      cmp({txFracSel, pllSel, txRst}, 3'h0);
      $display("frac test done");
   endtask

   // Transmitter held in reset stalls the drain, so the FIFO must fill
   task automatic testFifo();
      wb(1'b1, ADDR_CTRL, 32'h0000_0001, 4'hF);
      push(DEPTH);
      repeat (2) @(posedge mclk);
      cmp(srcReady, 1'b0);
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData & 32'h0000_1F07, 32'h0000_1005);
      // No slots are taken while held, so a cleared underrun count stays zero
      wb(1'b1, ADDR_STATUS, ZERO_WORD, 4'hC);
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData[31:16], 16'h0000);
      wb(1'b1, 8'h80, 32'h0000_FFFF, 4'hF);
      wb(1'b0, 8'h80, ZERO_WORD, 4'hF);
      cmp(rdData, ZERO_WORD);
      wb(1'b1, ADDR_CTRL, ZERO_WORD, 4'hF);
      waitRun();
      repeat (40) @(posedge mclk);
      wb(1'b0, ADDR_STATUS, ZERO_WORD, 4'hF);
      cmp(rdData & 32'h0000_1F07, 32'h0000_0002);
      cmp(rdData[31:16] != 16'h0000, 1'b1);
      cmp(wordCount, DEPTH);
      cmp(lastWord, nextWord - 1);
      $display("fifo test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reset rises at time zero so the design is defined before the first edge
   initial begin
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      testReset();
      testHd();
      testSd();
      test3g();
      testFrac();
      testFifo();
      cmp(faults, 0);
      summarize();
   end

   // Whole run needs well under a thousand cycles; the watchdog allows ten thousand
   initial begin
      #40000;
      failures++;
      summarize();
   end
endmodule // sdi_tx_driver_tb
